/* File: rtl/spbr_top.sv */
// APB register front end of two serial port buffers with interrupt logic
module spbr_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [spbr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transmit line side, index 0 is port E, 1 is port F
    output logic [spbr_pkg::NPORT-1:0] tx_valid,
    input wire logic [spbr_pkg::NPORT-1:0] tx_ready,
    output spbr_pkg::spbr_tx_t [spbr_pkg::NPORT-1:0] tx_out,
    input wire logic [spbr_pkg::NPORT-1:0] tx_busy,
    // Receive line side
    input wire logic [spbr_pkg::NPORT-1:0] rx_valid,
    input wire spbr_pkg::spbr_rx_t [spbr_pkg::NPORT-1:0] rx_in,
    output logic [spbr_pkg::NPORT-1:0] rx_ready,
    input wire logic [spbr_pkg::NPORT-1:0] rx_overrun,
    // Interrupts
    output logic [spbr_pkg::NPORT-1:0] rx_req,
    output logic irq
);
    import spbr_pkg::*;

    // Returns {hit, offset} of an index against a port's four-word range
    function automatic logic [2:0] port_reg(input logic [IDX_W-1:0] idx,
                                            input logic [IDX_W-1:0] base);
        logic [IDX_W-1:0] diff;
        diff = idx - base;
        port_reg = {(diff[IDX_W-1:2] == '0), diff[1:0]};
    endfunction : port_reg

    localparam logic [IDX_W-1:0] PORT_BASE [NPORT] = '{
        IDX_PORT_E_BUFFER_DATA, IDX_PORT_F_BUFFER_DATA};

    logic [IDX_W-1:0] idx;
    logic aligned;
    logic setup_ph;
    logic access_ph;
    logic wr_ok;
    logic [NPORT-1:0] hit;
    logic [1:0] ofs [NPORT];
    logic [NPORT-1:0] rd_busy, rd_take, wr_take, stat_wr;
    spbr_tx_kind_t wr_kind [NPORT];
    logic [7:0] rx_byte [NPORT];
    logic [7:0] status [NPORT];
    logic [NPORT-1:0] ev_rx, ev_tx, ev_ovr;
    logic hit_irq, hit_mask, hit_ctrl, mapped;

    logic [31:0] prdata_r, prdata_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] mask_r, mask_nxt;
    logic [7:0] irqst_r, irqst_nxt;
    logic irq_r, irq_nxt;
    logic [7:0] events;

    assign idx = paddr[ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    // Only byte lane 0 carries register data; writes without it are dropped
    assign wr_ok = access_ph && pwrite && pstrb[0];

    generate
        for (genvar p = 0; p < NPORT; p++) begin : g_port
            logic [2:0] sel;
            assign sel = port_reg(idx, PORT_BASE[p]);
            assign hit[p] = sel[2] && aligned;
            assign ofs[p] = sel[1:0];
            assign rd_busy[p] = psel && !pwrite && hit[p] &&
                                (ofs[p] != OFS_STAT);
            assign rd_take[p] = rd_busy[p] && penable;
            assign wr_take[p] = wr_ok && hit[p] && (ofs[p] != OFS_STAT);
            assign stat_wr[p] = wr_ok && hit[p] && (ofs[p] == OFS_STAT);
            always_comb begin
                case (ofs[p])
                    OFS_ADDR0: wr_kind[p] = TXK_ADDR0;
                    OFS_ADDR1: wr_kind[p] = TXK_ADDR1;
                    default: wr_kind[p] = TXK_DATA;
                endcase
            end

            spbr_port u_port (
                .pclk(pclk),
                .presetn(presetn),
                .rd_busy(rd_busy[p]),
                .rd_take(rd_take[p]),
                .wr_take(wr_take[p]),
                .wr_kind(wr_kind[p]),
                .wr_data(pwdata[7:0]),
                .stat_wr(stat_wr[p]),
                .hdlc_mode(ctrl_r[p]),
                .tx_valid(tx_valid[p]),
                .tx_ready(tx_ready[p]),
                .tx_out(tx_out[p]),
                .tx_busy(tx_busy[p]),
                .rx_valid(rx_valid[p]),
                .rx_in(rx_in[p]),
                .rx_ready(rx_ready[p]),
                .rx_overrun(rx_overrun[p]),
                .rx_byte(rx_byte[p]),
                .status(status[p]),
                .rx_req(rx_req[p]),
                .ev_rx(ev_rx[p]),
                .ev_tx(ev_tx[p]),
                .ev_ovr(ev_ovr[p])
            );

            assign events[p*IRQ_STRIDE+IRQ_RX] = ev_rx[p];
            assign events[p*IRQ_STRIDE+IRQ_TX] = ev_tx[p];
            assign events[p*IRQ_STRIDE+IRQ_OVR] = ev_ovr[p];
            assign events[p*IRQ_STRIDE+3] = 1'b0;
        end
    endgenerate

    assign hit_irq = aligned && (idx == IDX_IRQ_STATUS);
    assign hit_mask = aligned && (idx == IDX_IRQ_MASK);
    assign hit_ctrl = aligned && (idx == IDX_CTRL);
    assign mapped = (|hit) || hit_irq || hit_mask || hit_ctrl;

    // Zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = access_ph && !mapped;
    assign prdata = prdata_r;
    assign irq = irq_r;

    always_comb begin
        prdata_nxt = prdata_r;
        if (setup_ph && !pwrite) begin
            prdata_nxt = 32'h0000_0000;
            for (int p = 0; p < NPORT; p++) begin
                if (hit[p]) begin
                    prdata_nxt[7:0] = (ofs[p] == OFS_STAT) ? status[p] :
                                      rx_byte[p];
                end
            end
            if (hit_irq) begin
                prdata_nxt[7:0] = irqst_r;
            end
            if (hit_mask) begin
                prdata_nxt[7:0] = mask_r;
            end
            if (hit_ctrl) begin
                prdata_nxt[7:0] = ctrl_r;
            end
        end
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        irqst_nxt = irqst_r;
        if (wr_ok && hit_ctrl) begin
            ctrl_nxt = pwdata[7:0];
        end
        if (wr_ok && hit_mask) begin
            mask_nxt = pwdata[7:0];
        end
        // Clear only what the read returned, so a newer event survives
        if (access_ph && !pwrite && hit_irq) begin
            irqst_nxt = irqst_nxt & ~prdata_r[7:0];
        end
        irqst_nxt = irqst_nxt | events;
        irq_nxt = |(irqst_nxt & mask_nxt);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            ctrl_r <= RST_CTRL;
            mask_r <= RST_MASK;
            irqst_r <= RST_IRQ;
            irq_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            ctrl_r <= ctrl_nxt;
            mask_r <= mask_nxt;
            irqst_r <= irqst_nxt;
            irq_r <= irq_nxt;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_load_e;
        rx_valid[0] && rx_ready[0];
    endsequence

    sequence s_read_e;
        rd_take[0] && !rx_valid[0];
    endsequence

    sequence s_wr_e(logic [1:0] o);
        wr_take[0] && (ofs[0] == o);
    endsequence

    chk_rd_buffer_byte: assert property (
        setup_ph && rd_busy[0] |=> prdata[7:0] == $past(rx_byte[0]))
        else $error("buffer read returned wrong byte");

    chk_wr_data_plain: assert property (
        s_wr_e(OFS_DATA) |=> tx_valid[0] && !tx_out[0].has_addr &&
            tx_out[0].data == $past(pwdata[7:0]))
        else $error("data write not queued as plain byte");

    chk_wr_addr_zero: assert property (
        s_wr_e(OFS_ADDR0) |=> tx_valid[0] && tx_out[0].has_addr &&
            !tx_out[0].addr_bit)
        else $error("address zero write not tagged zero");

    chk_hdlc_crc_end: assert property (
        s_wr_e(OFS_ADDR0) ##0 ctrl_r[0] |=> tx_out[0].end_crc &&
            tx_out[0].end_flag)
        else $error("frame end without crc and flag");

    chk_wr_addr_one: assert property (
        s_wr_e(OFS_ADDR1) |=> tx_valid[0] && tx_out[0].addr_bit)
        else $error("address one write not tagged one");

    chk_hdlc_flag_end: assert property (
        s_wr_e(OFS_ADDR1) ##0 ctrl_r[0] |=> tx_out[0].end_flag &&
            !tx_out[0].end_crc)
        else $error("frame end without closing flag");

    chk_rx_full_bit: assert property (
        s_load_e |=> status[0][ST_RX_FULL] ##0 (rx_byte[0] ==
            $past(rx_in[0].data)))
        else $error("receive full bit not set on load");

    chk_rx_empty_bit: assert property (
        s_read_e |=> !status[0][ST_RX_FULL] && !status[0][ST_ADDR])
        else $error("receive buffer not emptied by read");

    chk_rx_req_cycle: assert property (
        s_read_e |=> !rx_req[0])
        else $error("receive request not cleared by read");

    chk_rx_reload: assert property (
        rd_take[0] && rx_valid[0] |-> rx_ready[0] ##1 rx_req[0] &&
            status[0][ST_RX_FULL])
        else $error("waiting character not reloaded at once");

    chk_addr_flag: assert property (
        s_load_e |=> status[0][ST_ADDR] == $past(rx_in[0].addr_bit))
        else $error("address flag does not follow byte");

    chk_overrun_set: assert property (
        rx_overrun[0] |=> status[0][ST_OVERRUN] ##1
            (status[0][ST_OVERRUN] || $past(rd_take[0])))
        else $error("overrun flag wrong");

    chk_overrun_clear: assert property (
        rd_take[0] && !rx_overrun[0] |=> !status[0][ST_OVERRUN])
        else $error("overrun flag not cleared by read");

    chk_tx_full_clear: assert property (
        stat_wr[0] |=> !status[0][ST_TX_FULL] ##0 $rose(irqst_r[IRQ_TX]) ||
            !$past(status[0][ST_TX_FULL]) || $past(irqst_r[IRQ_TX]))
        else $error("status write did not empty transmit buffer");

    chk_port_isolate: assert property (
        wr_take[0] && !wr_take[1] |=> $stable(tx_out[1]))
        else $error("port E write disturbed port F");

    chk_irq_level: assert property (
        |(irqst_r & mask_r) |-> irq)
        else $error("unmasked event without interrupt");

endmodule : spbr_top

/* File: rtl/spbr_pkg.sv */
// Shared constants and types of the dual serial port buffer registers
package spbr_pkg;

    localparam int NPORT = 2;
    localparam int ADDR_W = 12;
    localparam int IDX_W = ADDR_W - 2;

    // Register indices; the APB byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PORT_E_BUFFER_DATA = 10'h0C8;
    localparam logic [IDX_W-1:0] IDX_PORT_E_BUFFER_ADDR_ZERO = 10'h0C9;
    localparam logic [IDX_W-1:0] IDX_PORT_E_BUFFER_ADDR_ONE = 10'h0CA;
    localparam logic [IDX_W-1:0] IDX_PORT_E_ASYNC_STATUS = 10'h0CB;
    localparam logic [IDX_W-1:0] IDX_PORT_F_BUFFER_DATA = 10'h0D8;
    localparam logic [IDX_W-1:0] IDX_PORT_F_BUFFER_ADDR_ZERO = 10'h0D9;
    localparam logic [IDX_W-1:0] IDX_PORT_F_BUFFER_ADDR_ONE = 10'h0DA;
    localparam logic [IDX_W-1:0] IDX_PORT_F_ASYNC_STATUS = 10'h0DB;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h0E0;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h0E1;
    localparam logic [IDX_W-1:0] IDX_CTRL = 10'h0E2;

    // Offsets of the four registers inside one port's range
    localparam logic [1:0] OFS_DATA = 2'h0;
    localparam logic [1:0] OFS_ADDR0 = 2'h1;
    localparam logic [1:0] OFS_ADDR1 = 2'h2;
    localparam logic [1:0] OFS_STAT = 2'h3;

    // Port status bit positions
    localparam int ST_RX_FULL = 7;
    localparam int ST_ADDR = 6;
    localparam int ST_OVERRUN = 5;
    localparam int ST_TX_FULL = 3;
    localparam int ST_TX_BUSY = 2;

    // Interrupt status and mask layout, four bits per port
    localparam int IRQ_RX = 0;
    localparam int IRQ_TX = 1;
    localparam int IRQ_OVR = 2;
    localparam int IRQ_STRIDE = 4;

    // Values after reset
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_IRQ = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;

    typedef enum logic [1:0] {
        TXK_DATA = 2'b00,
        TXK_ADDR0 = 2'b01,
        TXK_ADDR1 = 2'b10
    } spbr_tx_kind_t;

    typedef struct packed {
        logic [7:0] data;
        logic has_addr;
        logic addr_bit;
        logic end_crc;
        logic end_flag;
    } spbr_tx_t;

    typedef struct packed {
        logic [7:0] data;
        logic addr_bit;
    } spbr_rx_t;

endpackage : spbr_pkg

/* File: rtl/spbr_port.sv */
// One serial port: receive and transmit buffers with their status bits
module spbr_port (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Host side strobes
    input wire logic rd_busy,
    input wire logic rd_take,
    input wire logic wr_take,
    input wire spbr_pkg::spbr_tx_kind_t wr_kind,
    input wire logic [7:0] wr_data,
    input wire logic stat_wr,
    input wire logic hdlc_mode,
    // Transmit line side
    output logic tx_valid,
    input wire logic tx_ready,
    output spbr_pkg::spbr_tx_t tx_out,
    input wire logic tx_busy,
    // Receive line side
    input wire logic rx_valid,
    input wire spbr_pkg::spbr_rx_t rx_in,
    output logic rx_ready,
    input wire logic rx_overrun,
    // Results
    output logic [7:0] rx_byte,
    output logic [7:0] status,
    output logic rx_req,
    output logic ev_rx,
    output logic ev_tx,
    output logic ev_ovr
);
    import spbr_pkg::*;

    logic [7:0] rx_buf_r, rx_buf_nxt;
    logic rx_full_r, rx_full_nxt;
    logic addr_r, addr_nxt;
    logic ovr_r, ovr_nxt;
    logic req_r, req_nxt;
    logic tx_full_r, tx_full_nxt;
    spbr_tx_t tx_buf_r, tx_buf_nxt;
    logic rx_load;

    always_comb begin
        // While a buffer read is pending the byte must not change under it
        rx_ready = rd_busy ? rd_take : !rx_full_r;
        rx_load = rx_valid && rx_ready;
        rx_buf_nxt = rx_buf_r;
        rx_full_nxt = rx_full_r;
        addr_nxt = addr_r;
        ovr_nxt = ovr_r;
        req_nxt = req_r;
        if (rd_take) begin
            rx_full_nxt = 1'b0;
            addr_nxt = 1'b0;
            ovr_nxt = 1'b0;
            req_nxt = 1'b0;
        end
        if (rx_load) begin
            rx_buf_nxt = rx_in.data;
            rx_full_nxt = 1'b1;
            addr_nxt = rx_in.addr_bit;
            req_nxt = 1'b1;
        end
        if (rx_overrun) begin
            ovr_nxt = 1'b1;
        end
        tx_buf_nxt = tx_buf_r;
        tx_full_nxt = tx_full_r;
        if ((tx_full_r && tx_ready) || stat_wr) begin
            tx_full_nxt = 1'b0;
        end
        if (wr_take) begin
            tx_full_nxt = 1'b1;
            tx_buf_nxt.data = wr_data;
            tx_buf_nxt.has_addr = (wr_kind != TXK_DATA);
            tx_buf_nxt.addr_bit = (wr_kind == TXK_ADDR1);
            tx_buf_nxt.end_crc = hdlc_mode && (wr_kind == TXK_ADDR0);
            tx_buf_nxt.end_flag = hdlc_mode && (wr_kind != TXK_DATA);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_r <= RST_BYTE;
            rx_full_r <= 1'b0;
            addr_r <= 1'b0;
            ovr_r <= 1'b0;
            req_r <= 1'b0;
            tx_full_r <= 1'b0;
            tx_buf_r <= '0;
        end else begin
            rx_buf_r <= rx_buf_nxt;
            rx_full_r <= rx_full_nxt;
            addr_r <= addr_nxt;
            ovr_r <= ovr_nxt;
            req_r <= req_nxt;
            tx_full_r <= tx_full_nxt;
            tx_buf_r <= tx_buf_nxt;
        end
    end

    always_comb begin
        status = 8'h00;
        status[ST_RX_FULL] = rx_full_r;
        status[ST_ADDR] = addr_r;
        status[ST_OVERRUN] = ovr_r;
        status[ST_TX_FULL] = tx_full_r;
        status[ST_TX_BUSY] = tx_busy;
    end

    assign tx_valid = tx_full_r;
    assign tx_out = tx_buf_r;
    assign rx_byte = rx_buf_r;
    assign rx_req = req_r;
    assign ev_rx = rx_load;
    assign ev_tx = tx_full_r && !tx_full_nxt;
    assign ev_ovr = rx_overrun;

endmodule : spbr_port

/* File: verification/spbr_line_model.sv */
// Far-side line model of one serial port: takes bytes, offers chars
module spbr_line_model
    import spbr_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Transmit side
    input wire logic stall,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire spbr_tx_t tx_out,
    output logic tx_busy,
    // Receive side
    output logic rx_valid,
    output spbr_rx_t rx_in,
    input wire logic rx_ready,
    output logic rx_overrun
);
    timeunit 1ns;
    timeprecision 1ps;
    spbr_tx_t sent_q[$];
    spbr_rx_t pend_q[$];
    int ovr_req;
    int busy_n;

    function automatic void push_rx(input spbr_rx_t c);
        pend_q.push_back(c);
    endfunction : push_rx

    function automatic void mark_overrun();
        ovr_req++;
    endfunction : mark_overrun

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'h0;
            tx_busy <= 1'h0;
            rx_valid <= 1'h0;
            rx_in <= '0;
            rx_overrun <= 1'h0;
            busy_n = 0;
        end else begin
            if (tx_valid && tx_ready) begin
                sent_q.push_back(tx_out);
                busy_n = 3;
            end else if (busy_n > 0) begin
                busy_n--;
            end
            // Shifter stays busy a while, so ready drops meanwhile
            tx_busy <= busy_n > 0;
            tx_ready <= !stall && busy_n == 0;
            // A released line shows the inverse, never the old char
            if (rx_valid && rx_ready) begin
                rx_valid <= 1'h0;
                rx_in <= ~rx_in;
            end else if (!rx_valid && pend_q.size() > 0) begin
                rx_valid <= 1'h1;
                rx_in <= pend_q.pop_front();
            end
            rx_overrun <= ovr_req > 0;
            if (ovr_req > 0) begin
                ovr_req--;
            end
        end
    end
endmodule : spbr_line_model

/* File: verification/tb_top.sv */
// Self-checking bench of the dual serial port buffer registers
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import spbr_pkg::*;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb;
    logic [NPORT-1:0] tx_valid, tx_ready, tx_busy, rx_valid, rx_ready;
    logic [NPORT-1:0] rx_overrun, rx_req, stall, ovr, txf;
    spbr_tx_t [NPORT-1:0] tx_out;
    spbr_rx_t [NPORT-1:0] rx_in;
    spbr_rx_t rxq[NPORT][$];
    logic [7:0] eirq, emask;
    logic rerr;
    int bad_count, checked;

    spbr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_out(tx_out), .tx_busy(tx_busy), .rx_valid(rx_valid),
        .rx_in(rx_in), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
        .rx_req(rx_req), .irq(irq));

    for (genvar g = 0; g < NPORT; g++) begin : ln
        spbr_line_model line_u (.pclk(pclk), .presetn(presetn),
            .stall(stall[g]), .tx_valid(tx_valid[g]),
            .tx_ready(tx_ready[g]), .tx_out(tx_out[g]),
            .tx_busy(tx_busy[g]), .rx_valid(rx_valid[g]),
            .rx_in(rx_in[g]), .rx_ready(rx_ready[g]),
            .rx_overrun(rx_overrun[g]));
    end

    initial begin
        pclk = 1'h0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask : check

    task automatic stop_test();
        if (bad_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        stop_test();
    end

    task automatic idle(int n);
        repeat (n) @(posedge pclk);
    endtask : idle

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'h1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    function automatic logic [11:0] ra(int p, logic [1:0] o);
        return {(p == 1 ? IDX_PORT_F_BUFFER_DATA : IDX_PORT_E_BUFFER_DATA)
                + {8'h00, o}, 2'h0};
    endfunction : ra

    function automatic logic [7:0] est(int p);
        logic f;
        f = rxq[p].size() > 0;
        return {f, f ? rxq[p][0].addr_bit : 1'h0, ovr[p], 1'h0, txf[p],
                3'h0};
    endfunction : est

    task automatic cst(int p);
        apb(1'h0, ra(p, OFS_STAT), 8'h00);
        check(rdat, {24'h000000, est(p)});
    endtask : cst

    task automatic cirq();
        apb(1'h0, {IDX_IRQ_STATUS, 2'h0}, 8'h00);
        check(rdat, {24'h000000, eirq});
        eirq = 8'h00;
        idle(2);
        check(irq, |(eirq & emask));
    endtask : cirq

    task automatic push(int p, spbr_rx_t c);
        if (rxq[p].size() == 0) begin
            eirq[IRQ_STRIDE * p + IRQ_RX] = 1'h1;
        end
        rxq[p].push_back(c);
        if (p == 0) ln[0].line_u.push_rx(c);
        else ln[1].line_u.push_rx(c);
        idle(6);
    endtask : push

    task automatic rdb(int p, logic [1:0] o);
        apb(1'h0, ra(p, o), 8'h00);
        check(rdat, {24'h000000, rxq[p][0].data});
        void'(rxq[p].pop_front());
        ovr[p] = 1'h0;
        if (rxq[p].size() > 0) begin
            eirq[IRQ_STRIDE * p + IRQ_RX] = 1'h1;
        end
        idle(4);
    endtask : rdb

    task automatic txw(int p, logic [1:0] o, logic h);
        spbr_tx_t e;
        logic [7:0] d;
        d = 8'($urandom);
        e = '{d, o != OFS_DATA, o == OFS_ADDR1, h && o == OFS_ADDR0,
              h && o != OFS_DATA};
        stall[p] <= 1'h1;
        apb(1'h1, ra(p, o), d);
        txf[p] = 1'h1;
        idle(3);
        check(tx_out[p], e);
        cst(p);
        stall[p] <= 1'h0;
        idle(10);
        check(p == 0 ? ln[0].line_u.sent_q[$] : ln[1].line_u.sent_q[$],
              e);
        txf[p] = 1'h0;
        eirq[IRQ_STRIDE * p + IRQ_TX] = 1'h1;
        cst(p);
    endtask : txw

    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        stall = '0;
        presetn = 1'h0;
        {ovr, txf, eirq, emask} = '0;
        bad_count = 0;
        checked = 0;
        void'($urandom(32'h7bb9));
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        for (int p = 0; p < NPORT; p++) begin
            cst(p);
        end
        apb(1'h0, {IDX_IRQ_MASK, 2'h0}, 8'h00);
        check(rdat, {24'h000000, RST_MASK});
        apb(1'h0, 12'h3F0, 8'h00);
        check(rerr, 1'h1);
        check(rdat, 32'h0000_0000);
        apb(1'h0, 12'h321, 8'h00);
        check(rerr, 1'h1);
        // Only the port E receive event reaches the interrupt line
        emask = 8'h01;
        apb(1'h1, {IDX_IRQ_MASK, 2'h0}, emask);
        // A write without byte lane 0 must leave the register alone
        pstrb <= 4'hE;
        apb(1'h1, {IDX_CTRL, 2'h0}, 8'hFF);
        pstrb <= 4'hF;
        apb(1'h0, {IDX_CTRL, 2'h0}, 8'h00);
        check(rdat, {24'h000000, RST_CTRL});
        for (int h = 0; h < 2; h++) begin
            apb(1'h1, {IDX_CTRL, 2'h0}, h ? 8'h03 : 8'h00);
            for (int p = 0; p < NPORT; p++) begin
                for (int o = 0; o < 3; o++) begin
                    txw(p, 2'(o), h[0]);
                end
            end
        end
        apb(1'h1, {IDX_CTRL, 2'h0}, 8'h00);
        stall[0] <= 1'h1;
        apb(1'h1, ra(0, OFS_ADDR1), 8'h5A);
        txf[0] = 1'h1;
        apb(1'h1, ra(0, OFS_STAT), 8'h00);
        txf[0] = 1'h0;
        eirq[IRQ_TX] = 1'h1;
        idle(2);
        cst(0);
        check(tx_valid[0], 1'h0);
        stall[0] <= 1'h0;
        cirq();
        for (int p = 0; p < NPORT; p++) begin
            push(p, '{8'($urandom), 1'h0});
            push(p, '{8'($urandom), 1'h1});
            check(rx_req[p], 1'h1);
            check(irq, |(eirq & emask));
            cst(p);
            cst(1 - p);
            rdb(p, OFS_DATA);
            check(rx_req[p], 1'h1);
            cst(p);
            rdb(p, OFS_ADDR1);
            check(rx_req[p], 1'h0);
            cst(p);
            cirq();
            // All-zero byte with the flag stands for a break
            push(p, '{8'h00, 1'h1});
            if (p == 0) ln[0].line_u.mark_overrun();
            else ln[1].line_u.mark_overrun();
            ovr[p] = 1'h1;
            eirq[IRQ_STRIDE * p + IRQ_OVR] = 1'h1;
            idle(4);
            cst(p);
            rdb(p, OFS_ADDR0);
            cst(p);
            cirq();
        end
        stop_test();
    end
endmodule : tb_top
